// ### rtl/rx_gain_bitsync_config.sv
// Receiver gain limit and bit-sync configuration bank behind the serial register port
// Overview of operation
// - After sync, bit 3 picks the pre-sync integral gain (0) or half the base gain (1).
// - After sync, bit 2 picks the pre-sync proportional gain (0) or the base gain (1); reset 1.
// - Bits 1:0 cap the compensated rate offset at none, 3.125, 6.25 or 12.5 percent; reset 0.
// - Bits 7:6 of the gain limit register exclude that many top digital gain settings; reset 0.
// - Bits 5:3 cap front-end gain at maximum or 2.6 to 17.1 dB below it.
// - Bits 2:0 pick the amplitude target of 24 to 42 dB; reset 3.
// - Before sync the integral gain is one to four times the base set by bits 7:6.
// - Before sync the proportional gain is one to four times the base set by bits 5:4.
`timescale 1ns/1ns
module rx_gain_bitsync_config
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       sync_detected,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sclk,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  output logic            spi_miso_oe_n,
  output logic [3:0]      integral_gain_halves,
  output logic [2:0]      proportional_gain,
  output logic [2:0]      rate_offset_saturation,
  output logic [1:0]      digital_gain_ceiling,
  output logic [7:0]      front_end_gain_ceiling,
  output logic [5:0]      amplitude_target
);
  // Cap in tenths of a dB below maximum
  function automatic logic [7:0] lna_cap_tenths(input logic [2:0] c);
    case (c)
      3'h0:    lna_cap_tenths = 8'h00;
      3'h1:    lna_cap_tenths = 8'h1A;
      3'h2:    lna_cap_tenths = 8'h3D;
      3'h3:    lna_cap_tenths = 8'h4A;
      3'h4:    lna_cap_tenths = 8'h5C;
      3'h5:    lna_cap_tenths = 8'h73;
      3'h6:    lna_cap_tenths = 8'h92;
      default: lna_cap_tenths = 8'hAB;
    endcase
  endfunction

  function automatic logic [5:0] target_db(input logic [2:0] c);
    case (c)
      3'h0:    target_db = 6'h18;
      3'h1:    target_db = 6'h1B;
      3'h2:    target_db = 6'h1E;
      3'h3:    target_db = 6'h21;
      3'h4:    target_db = 6'h24;
      3'h5:    target_db = 6'h26;
      3'h6:    target_db = 6'h28;
      default: target_db = 6'h2A;
    endcase
  endfunction

  function automatic logic [2:0] rate_off(input logic [1:0] c);
    case (c)
      2'h0:    rate_off = rx_gain_bitsync_pkg::RATE_OFF_0;
      2'h1:    rate_off = rx_gain_bitsync_pkg::RATE_OFF_1;
      2'h2:    rate_off = rx_gain_bitsync_pkg::RATE_OFF_2;
      default: rate_off = rx_gain_bitsync_pkg::RATE_OFF_3;
    endcase
  endfunction

  // Pin synchronisers: cs_n, sclk, mosi in bits 2..0
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [2:0] pin_r;
  logic       sclk_prev_r;

  logic [7:0] bit_sync_config_r;
  logic [7:0] rx_gain_limit_target_r;
  logic [2:0] bit_cnt_r;
  logic       hdr_done_r;
  logic       rw_r;
  logic       burst_r;
  logic [5:0] addr_r;
  logic [6:0] shift_in_r;
  logic [7:0] shift_out_r;
  logic       live_r;

  // A pin level is accepted only once two later stages agree, which rejects single glitches
  wire [2:0] pin_nxt = (s2_r ~^ s3_r) & s3_r | (s2_r ^ s3_r) & pin_r;
  wire       cs_act  = ~pin_r[2];
  wire       sclk_f  = pin_r[1];
  wire       mosi_f  = pin_r[0];
  wire       rise    = cs_act & sclk_f & ~sclk_prev_r;
  wire       fall    = cs_act & ~sclk_f & sclk_prev_r;
  wire [7:0] byte_in = {shift_in_r, mosi_f};
  wire       byte_end = rise & (bit_cnt_r == rx_gain_bitsync_pkg::LAST_BIT);
  wire       data_end = byte_end & hdr_done_r;
  wire [5:0] hdr_addr = byte_in[5:0];
  wire [5:0] next_addr = burst_r ? addr_r + 6'h01 : addr_r;
  wire [5:0] rd_addr  = hdr_done_r ? next_addr : hdr_addr;
  wire       wr_en    = data_end & ~rw_r;
  wire       wr_bsc   = wr_en & (addr_r == rx_gain_bitsync_pkg::BIT_SYNC_CONFIG_ADDR);
  wire       wr_agc   = wr_en & (addr_r == rx_gain_bitsync_pkg::RX_GAIN_LIMIT_TARGET_ADDR);

  // Read data comes from the stored values; a burst is all reads or all writes, so it never reads back its own writes
  wire [7:0] rd_data =
    (rd_addr == rx_gain_bitsync_pkg::BIT_SYNC_CONFIG_ADDR)      ? bit_sync_config_r :
    (rd_addr == rx_gain_bitsync_pkg::RX_GAIN_LIMIT_TARGET_ADDR) ? rx_gain_limit_target_r :
    8'h00;
  wire       rd_load = byte_end & (hdr_done_r ? rw_r : byte_in[rx_gain_bitsync_pkg::HDR_RW_BIT]);

  wire [1:0] pre_ki  = bit_sync_config_r[rx_gain_bitsync_pkg::PRE_KI_LSB +: 2];
  wire [1:0] pre_kp  = bit_sync_config_r[rx_gain_bitsync_pkg::PRE_KP_LSB +: 2];
  wire       post_ki = bit_sync_config_r[rx_gain_bitsync_pkg::POST_KI_BIT];
  wire       post_kp = bit_sync_config_r[rx_gain_bitsync_pkg::POST_KP_BIT];
  wire [1:0] rsat    = bit_sync_config_r[rx_gain_bitsync_pkg::RATE_SAT_LSB +: 2];
  wire [2:0] pre_ki_mult   = {1'b0, pre_ki} + 3'h1;
  wire [3:0] pre_ki_halves = {pre_ki_mult, 1'b0};
  wire [2:0] pre_kp_mult   = {1'b0, pre_kp} + 3'h1;
  wire [1:0] dvga_code     = rx_gain_limit_target_r[rx_gain_bitsync_pkg::DVGA_LSB +: 2];
  wire [2:0] lna_code      = rx_gain_limit_target_r[rx_gain_bitsync_pkg::LNA_LSB +: 3];
  wire [2:0] tgt_code      = rx_gain_limit_target_r[rx_gain_bitsync_pkg::TARGET_LSB +: 3];
  wire [3:0] ki_nxt = (sync_detected & post_ki) ? rx_gain_bitsync_pkg::KI_HALF_POST
                                                : pre_ki_halves;
  wire [2:0] kp_nxt = (sync_detected & post_kp) ? rx_gain_bitsync_pkg::KP_POST
                                                : pre_kp_mult;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // Idle pin levels (deselected, clock low) so no false clock edge follows reset
      s1_r        <= 3'h4;
      s2_r        <= 3'h4;
      s3_r        <= 3'h4;
      pin_r       <= 3'h4;
      sclk_prev_r <= 1'b0;
    end
    else if (ce)
    begin
      s1_r        <= {spi_cs_n, spi_sclk, spi_mosi};
      s2_r        <= s1_r;
      s3_r        <= s2_r;
      pin_r       <= pin_nxt;
      sclk_prev_r <= sclk_f;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt_r  <= 3'h0;
      hdr_done_r <= 1'b0;
      rw_r       <= 1'b0;
      burst_r    <= 1'b0;
      addr_r     <= 6'h00;
      shift_in_r <= 7'h00;
    end
    else if (ce)
    begin
      if (!cs_act)
      begin
        bit_cnt_r  <= 3'h0;
        hdr_done_r <= 1'b0;
      end
      else if (rise)
      begin
        bit_cnt_r  <= bit_cnt_r + 3'h1;
        shift_in_r <= byte_in[6:0];
        if (byte_end && !hdr_done_r)
        begin
          hdr_done_r <= 1'b1;
          rw_r       <= byte_in[rx_gain_bitsync_pkg::HDR_RW_BIT];
          burst_r    <= byte_in[rx_gain_bitsync_pkg::HDR_BURST_BIT];
          addr_r     <= hdr_addr;
        end
        else if (data_end)
          addr_r <= next_addr;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shift_out_r   <= 8'h00;
      spi_miso      <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      spi_miso_oe_n <= ~cs_act;
      if (!cs_act)
        shift_out_r <= 8'h00;
      else if (byte_end)
        shift_out_r <= rd_load ? rd_data : 8'h00;
      else if (fall)
      begin
        spi_miso    <= shift_out_r[7];
        shift_out_r <= {shift_out_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bit_sync_config_r      <= rx_gain_bitsync_pkg::BIT_SYNC_CONFIG_RST;
      rx_gain_limit_target_r <= rx_gain_bitsync_pkg::RX_GAIN_LIMIT_TARGET_RST;
    end
    else if (ce)
    begin
      if (wr_bsc)
        bit_sync_config_r <= byte_in;
      if (wr_agc)
        rx_gain_limit_target_r <= byte_in;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      integral_gain_halves   <= 4'h0;
      proportional_gain      <= 3'h0;
      rate_offset_saturation <= 3'h0;
      digital_gain_ceiling   <= 2'h0;
      front_end_gain_ceiling <= 8'h00;
      amplitude_target       <= 6'h00;
    end
    else if (ce)
    begin
      integral_gain_halves   <= ki_nxt;
      proportional_gain      <= kp_nxt;
      rate_offset_saturation <= rate_off(rsat);
      digital_gain_ceiling   <= dvga_code;
      front_end_gain_ceiling <= lna_cap_tenths(lna_code);
      amplitude_target       <= target_db(tgt_code);
    end
  end

  // Output checks wait one enabled cycle after reset, while the output flops still hold zeros
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      live_r <= 1'b0;
    else if (ce)
      live_r <= 1'b1;
  end

  sequence s_post_ki;
    ce && live_r && sync_detected && post_ki;
  endsequence

  a_post_ki_half: assert property (@(posedge clk) disable iff (rst)
    s_post_ki |=> integral_gain_halves == 4'h1)
    else $error("post-sync integral gain not halved");
  a_post_kp_base: assert property (@(posedge clk) disable iff (rst)
    ce && live_r && sync_detected && post_kp |=> proportional_gain == 3'h1)
    else $error("post-sync proportional gain not base");
  a_rate_sat_map: assert property (@(posedge clk) disable iff (rst)
    ce && live_r && rsat == 2'h3 |=> rate_offset_saturation == 3'h4)
    else $error("rate offset ceiling wrong");
  a_dvga_ceiling: assert property (@(posedge clk) disable iff (rst)
    ce && live_r |=> digital_gain_ceiling == $past(dvga_code))
    else $error("digital gain ceiling wrong");
  a_lna_cap_max: assert property (@(posedge clk) disable iff (rst)
    ce && live_r && lna_code == 3'h7 |=> front_end_gain_ceiling == 8'hAB)
    else $error("front-end cap wrong");
  a_amp_target: assert property (@(posedge clk) disable iff (rst)
    ce && live_r && tgt_code == 3'h0 |=> amplitude_target == 6'h18)
    else $error("amplitude target wrong");
  a_pre_ki_mult: assert property (@(posedge clk) disable iff (rst)
    ce && live_r && !sync_detected |=> integral_gain_halves == {$past(pre_ki) + 3'h1, 1'b0})
    else $error("pre-sync integral gain wrong");
  a_pre_kp_mult: assert property (@(posedge clk) disable iff (rst)
    ce && live_r && !sync_detected |=> proportional_gain == $past(pre_kp) + 3'h1)
    else $error("pre-sync proportional gain wrong");
  a_write_store: assert property (@(posedge clk) disable iff (rst)
    ce && wr_bsc |=> bit_sync_config_r == $past(byte_in) ##1 $stable(bit_sync_config_r) || wr_bsc)
    else $error("register write not stored");
endmodule

// ### include/rx_gain_bitsync_pkg.sv
// Register map, field layout, reset values and lookup constants for the receiver tuning bank
package rx_gain_bitsync_pkg;
  localparam logic [5:0] BIT_SYNC_CONFIG_ADDR      = 6'h1A;
  localparam logic [5:0] RX_GAIN_LIMIT_TARGET_ADDR = 6'h1B;
  localparam logic [7:0] BIT_SYNC_CONFIG_RST       = 8'h6C;
  localparam logic [7:0] RX_GAIN_LIMIT_TARGET_RST  = 8'h03;

  // bit_sync_config fields
  localparam int PRE_KI_LSB   = 6;
  localparam int PRE_KP_LSB   = 4;
  localparam int POST_KI_BIT  = 3;
  localparam int POST_KP_BIT  = 2;
  localparam int RATE_SAT_LSB = 0;
  // rx_gain_limit_target fields
  localparam int DVGA_LSB     = 6;
  localparam int LNA_LSB      = 3;
  localparam int TARGET_LSB   = 0;

  // Serial header byte layout
  localparam int HDR_RW_BIT    = 7;
  localparam int HDR_BURST_BIT = 6;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Half-unit integral gain for the halved post-sync choice
  localparam logic [3:0] KI_HALF_POST = 4'h1;
  localparam logic [2:0] KP_POST      = 3'h1;

  // Rate offset ceiling in units of 1/32 (3.125 %)
  localparam logic [2:0] RATE_OFF_0 = 3'h0;
  localparam logic [2:0] RATE_OFF_1 = 3'h1;
  localparam logic [2:0] RATE_OFF_2 = 3'h2;
  localparam logic [2:0] RATE_OFF_3 = 3'h4;
endpackage

// ### sim/tb_top.sv
// Self-checking bench for the receiver gain and bit-sync configuration bank
`timescale 1ns/1ns
module tb_top;
  logic       clk;
  logic       rst;
  logic       ce;
  logic       sync_det;
  logic       cs_n;
  logic       sclk;
  logic       mosi;
  logic       miso;
  logic       oe_n;
  logic [3:0] ki;
  logic [2:0] kp;
  logic [2:0] rate;
  logic [1:0] dvga;
  logic [7:0] lna;
  logic [5:0] tgt;
  int         err_count = 0;
  int         tests_run = 0;
  int         cycles    = 0;
  logic [7:0] lna_tab [8] = '{8'h00, 8'h1A, 8'h3D, 8'h4A, 8'h5C, 8'h73, 8'h92, 8'hAB};
  logic [5:0] tgt_tab [8] = '{6'h18, 6'h1B, 6'h1E, 6'h21, 6'h24, 6'h26, 6'h28, 6'h2A};
  logic [2:0] rate_tab [4] = '{3'h0, 3'h1, 3'h2, 3'h4};

  rx_gain_bitsync_config i_rx_gain_bitsync_config
  (
    .clk                    (clk),
    .rst                    (rst),
    .ce                     (ce),
    .sync_detected          (sync_det),
    .spi_cs_n               (cs_n),
    .spi_sclk               (sclk),
    .spi_mosi               (mosi),
    .spi_miso               (miso),
    .spi_miso_oe_n          (oe_n),
    .integral_gain_halves   (ki),
    .proportional_gain      (kp),
    .rate_offset_saturation (rate),
    .digital_gain_ceiling   (dvga),
    .front_end_gain_ceiling (lna),
    .amplitude_target       (tgt)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Generous ceiling: each register transfer takes about 350 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_count++;
      give_verdict();
    end
  end

  task give_verdict;
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Sclk phases of 10 cycles clear the pin synchronisers with margin
  task spi_byte(input logic [7:0] d, output logic [7:0] q);
    for (int b = 7; b >= 0; b--)
    begin
      mosi <= d[b];
      wait_clk(10);
      q[b] = miso;
      sclk <= 1'b1;
      wait_clk(10);
      sclk <= 1'b0;
    end
  endtask

  task xfer(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] q);
    logic [7:0] junk;
    cs_n <= 1'b0;
    wait_clk(8);
    chk({7'h00, oe_n}, 8'h00);
    spi_byte(hdr, junk);
    spi_byte(wd, q);
    wait_clk(8);
    cs_n <= 1'b1;
    wait_clk(12);
    chk({7'h00, oe_n}, 8'h01);
  endtask

  task wr(input logic [5:0] a, input logic [7:0] v);
    logic [7:0] q;
    xfer({2'b00, a}, v, q);
  endtask

  task rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] q;
    xfer({2'b10, a}, 8'h00, q);
    chk(q, exp);
  endtask

  task t_reset_values;
    chk({4'h0, ki}, 8'h04);
    chk({5'h00, kp}, 8'h03);
    chk({5'h00, rate}, 8'h00);
    chk({6'h00, dvga}, 8'h00);
    chk(lna, 8'h00);
    chk({2'h0, tgt}, 8'h21);
    rd_chk(rx_gain_bitsync_pkg::BIT_SYNC_CONFIG_ADDR, 8'h6C);
    rd_chk(rx_gain_bitsync_pkg::RX_GAIN_LIMIT_TARGET_ADDR, 8'h03);
  endtask

  task t_gain_limits;
    logic [7:0] v;
    for (int i = 0; i < 8; i++)
    begin
      v = {i[1:0], i[2:0], 3'(7 - i)};
      wr(rx_gain_bitsync_pkg::RX_GAIN_LIMIT_TARGET_ADDR, v);
      chk({6'h00, dvga}, {6'h00, v[7:6]});
      chk(lna, lna_tab[i]);
      chk({2'h0, tgt}, {2'h0, tgt_tab[7 - i]});
      rd_chk(rx_gain_bitsync_pkg::RX_GAIN_LIMIT_TARGET_ADDR, v);
    end
  endtask

  task t_bit_sync;
    logic [7:0] v;
    for (int i = 0; i < 4; i++)
    begin
      v = {i[1:0], 2'(3 - i), i[0], i[1], i[1:0]};
      wr(rx_gain_bitsync_pkg::BIT_SYNC_CONFIG_ADDR, v);
      chk({4'h0, ki}, 8'(2 * (i + 1)));
      chk({5'h00, kp}, 8'(4 - i));
      chk({5'h00, rate}, {5'h00, rate_tab[i]});
      sync_det <= 1'b1;
      wait_clk(2);
      chk({4'h0, ki}, v[3] ? 8'h01 : 8'(2 * (i + 1)));
      chk({5'h00, kp}, v[2] ? 8'h01 : 8'(4 - i));
      sync_det <= 1'b0;
      wait_clk(2);
      chk({5'h00, kp}, 8'(4 - i));
      rd_chk(rx_gain_bitsync_pkg::BIT_SYNC_CONFIG_ADDR, v);
    end
  endtask

  // Three-byte transfer: header then two data bytes, for address auto-increment
  task xfer2(input logic [7:0] hdr, input logic [7:0] d1, input logic [7:0] d2,
             output logic [7:0] q1, output logic [7:0] q2);
    logic [7:0] junk;
    cs_n <= 1'b0;
    wait_clk(8);
    spi_byte(hdr, junk);
    spi_byte(d1, q1);
    spi_byte(d2, q2);
    wait_clk(8);
    cs_n <= 1'b1;
    wait_clk(12);
  endtask

  // Register holds 0xCF here: pre-sync integral 8 halves, post-sync 1 half
  task t_clock_enable;
    ce       <= 1'b0;
    sync_det <= 1'b1;
    wait_clk(4);
    chk({4'h0, ki}, 8'h08);
    ce <= 1'b1;
    wait_clk(2);
    chk({4'h0, ki}, 8'h01);
    sync_det <= 1'b0;
    wait_clk(2);
    chk({4'h0, ki}, 8'h08);
  endtask

  task t_burst;
    logic [7:0] q1;
    logic [7:0] q2;
    xfer2({2'b01, rx_gain_bitsync_pkg::BIT_SYNC_CONFIG_ADDR}, 8'h39, 8'h9D, q1, q2);
    chk({4'h0, ki}, 8'h02);
    chk({5'h00, kp}, 8'h04);
    chk({5'h00, rate}, 8'h01);
    chk({6'h00, dvga}, 8'h02);
    chk(lna, 8'h4A);
    chk({2'h0, tgt}, 8'h26);
    xfer2({2'b11, rx_gain_bitsync_pkg::BIT_SYNC_CONFIG_ADDR}, 8'h00, 8'h00, q1, q2);
    chk(q1, 8'h39);
    chk(q2, 8'h9D);
  endtask

  task t_unmapped_and_reset;
    rd_chk(6'h00, 8'h00);
    wr(6'h3F, 8'hA5);
    rd_chk(6'h3F, 8'h00);
    rst <= 1'b1;
    wait_clk(2);
    rst <= 1'b0;
    wait_clk(4);
    chk({2'h0, tgt}, 8'h21);
    rd_chk(rx_gain_bitsync_pkg::BIT_SYNC_CONFIG_ADDR, 8'h6C);
  endtask

  initial
  begin
    rst      = 1'b1;
    ce       = 1'b1;
    sync_det = 1'b0;
    cs_n     = 1'b1;
    sclk     = 1'b0;
    mosi     = 1'b0;
    wait_clk(10);
    rst <= 1'b0;
    wait_clk(4);
    t_reset_values();
    t_gain_limits();
    t_bit_sync();
    t_clock_enable();
    t_burst();
    t_unmapped_and_reset();
    give_verdict();
  end
endmodule
